//--- epu_pkg.sv
// Constants shared by the energy pulse output unit and its helpers.
// Assumes a 125 MHz system clock and 24-bit signed energy samples.
package epu_pkg;
  // Clock and sample timing
  localparam int CLK_PERIOD_NS      = 8;
  localparam int SAMPLE_PERIOD_US   = 250;
  localparam int SAMPLE_CYCLES      = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_PLEN     = 8'h04;
  localparam logic [7:0] OFS_RATE     = 8'h08;
  localparam logic [7:0] OFS_NOLOAD   = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_EPULSE   = 8'h14;
  localparam logic [7:0] OFS_QPULSE   = 8'h18;

  // Mode register field positions
  localparam int MODE_A_LSB    = 0;
  localparam int MODE_B_LSB    = 2;
  localparam int MODE_C_LSB    = 4;
  localparam int MODE_HOLD_BIT = 6;
  localparam int MODE_CHAN_BIT = 7;

  // Reset values
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [15:0] PLEN_RST   = 16'h0001;
  localparam logic [23:0] RATE_RST   = 24'h000000;
  localparam logic [23:0] NOLOAD_RST = 24'h000000;

  // Output b selections
  localparam logic [1:0] B_SIGN     = 2'h0;
  localparam logic [1:0] B_APPARENT = 2'h1;
  localparam logic [1:0] B_CHANNEL  = 2'h2;
  localparam logic [1:0] B_A_ENABLE = 2'h3;

  // Output c selections, normal and paired mode
  localparam logic [1:0] C_REACTIVE = 2'h0;
  localparam logic [1:0] C_FAIL     = 2'h1;
  localparam logic [1:0] C_VSIGN    = 2'h2;
  localparam logic [1:0] C_APPARENT = 2'h3;
  localparam logic [1:0] CP_FAIL    = 2'h0;
  localparam logic [1:0] CP_SIGN    = 2'h1;

  // Energy kinds for paired mode
  localparam logic [1:0] K_ACTIVE   = 2'h0;
  localparam logic [1:0] K_APPARENT = 2'h1;
  localparam logic [1:0] K_REACTIVE = 2'h2;
  localparam logic [1:0] K_WIDEBAND = 2'h3;
endpackage

//--- level_sync.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the level is slow compared with the clock.
module level_sync (
  input  wire logic clk_i,    // System clock
  input  wire logic rst_i,    // Synchronous reset, active high
  input  wire logic async_i,  // Level from a pin
  output logic      sync_o    // Level in the clock domain
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

//--- rate_pulser.sv
// Rate accumulator and pulse stretcher for one energy output.
// Assumes tick_i is a one-cycle strobe once per output-word-rate sample.
module rate_pulser
  import epu_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Synchronous reset, active high
  input  wire logic        tick_i,    // Sample strobe
  input  wire logic        enable_i,  // Output configured for pulses
  input  wire logic [22:0] mag_i,     // Pulse register magnitude
  input  wire logic [23:0] rate_i,    // Full-scale rate fraction
  input  wire logic [15:0] len_i,     // Pulse length in samples
  output logic             pulse_o    // Active-high pulse
);
  logic [47:0] acc;
  logic [48:0] sum;
  logic [15:0] remain;
  logic        carry;

  // Unit is two to the 48th, which halves the rate
  // Operands widened first; inside a concatenation the product would keep only 24 bits
  assign sum   = {1'b0, acc} + {2'b00, 47'(mag_i) * 47'(rate_i)};
  assign carry = tick_i && enable_i && sum[48];

  // Accumulate once per sample; idle outputs hold nothing
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      acc <= 48'h000000000000;
    end else if (tick_i) begin
      acc <= sum[47:0]; // RULE9 RULE10 RULE14
    end
  end

  // Overflow during a pulse is dropped to keep the width honest
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      remain <= 16'h0000;
    end else if (carry && remain == 16'h0000) begin
      remain <= (len_i == 16'h0000) ? 16'h0001 : len_i; // RULE8
    end else if (tick_i && remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end

  assign pulse_o = (remain != 16'h0000);

  a_pulse_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pulse_o) |-> $past(carry)) else $error("pulse began without overflow"); // RULE14
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !pulse_o) else $error("pulse on a steady output"); // RULE7
endmodule

//--- energy_pulse_output_unit.sv
// Energy pulse output unit: three active-low outputs with a Wishbone slave.
// Assumes energy inputs are synchronous signed fractions, stable per sample.
// Operation
// RULE1 - Defaults give active, sign, reactive outputs
// RULE2 - Output b selects sign, apparent, channel, pairing
// RULE3 - Output c selects reactive, fail, vsign, apparent
// RULE4 - Paired mode: a,b carry one kind
// RULE5 - Paired mode c: fail or sign
// RULE6 - Small active, reactive values forced zero
// RULE7 - Steady outputs ignore width and rate
// RULE8 - Pulse lasts length times sample period
// RULE9 - Full scale is rate times rate/2
// RULE10 - Actual rate scales by pulse register
// RULE11 - Channel output shows channel in use
// RULE12 - Channel bit auto or software held
// RULE13 - Fail status from supply comparator input
// RULE14 - Accumulate magnitude, pulse on overflow
module energy_pulse_output_unit
  import epu_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES  // Clocks per sample period
) (
  input  wire logic        clk_i,              // System clock, 125 MHz
  input  wire logic        rst_i,              // Synchronous reset, active high
  input  wire logic        wb_cyc_i,           // Wishbone cycle
  input  wire logic        wb_stb_i,           // Wishbone strobe
  input  wire logic        wb_we_i,            // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,           // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,           // Wishbone byte enables
  input  wire logic [31:0] wb_dat_i,           // Wishbone write data
  output logic      [31:0] wb_dat_o,           // Wishbone read data
  output logic             wb_ack_o,           // Wishbone acknowledge
  input  wire logic [23:0] act1_i,             // Channel 1 active energy
  input  wire logic [23:0] act2_i,             // Channel 2 active energy
  input  wire logic [23:0] app1_i,             // Channel 1 apparent energy
  input  wire logic [23:0] app2_i,             // Channel 2 apparent energy
  input  wire logic [23:0] rea1_i,             // Channel 1 reactive energy
  input  wire logic [23:0] rea2_i,             // Channel 2 reactive energy
  input  wire logic [23:0] wbr1_i,             // Channel 1 wideband reactive
  input  wire logic [23:0] wbr2_i,             // Channel 2 wideband reactive
  input  wire logic        auto_chan_i,        // Automatic pick, 1 = channel 2
  input  wire logic        voltage_neg_i,      // Voltage sample is negative
  input  wire logic        supply_fail_input_i,// Supply comparator, high = low
  output logic             pulse_out_a_n_o,    // Output a, active low
  output logic             pulse_out_b_n_o,    // Output b, active low
  output logic             pulse_out_c_n_o,    // Output c, active low
  output logic             sample_tick_o       // Sample strobe, one cycle
);

  // Magnitude of a signed fraction, saturated to 23 bits
  function automatic logic [22:0] mag(input logic [23:0] v);
    logic [23:0] n;
    n = 24'h000000 - v;
    if (!v[23]) mag = v[22:0];
    else if (n[23]) mag = 23'h7FFFFF;
    else mag = n[22:0];
  endfunction

  // Values below the threshold read as zero
  function automatic logic [23:0] noload(input logic [23:0] v, input logic [23:0] th);
    noload = ({1'b0, mag(v)} < th) ? 24'h000000 : v;
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [7:0]  mode_reg;
  logic [15:0] pulse_len_reg;
  logic [23:0] full_scale_rate_reg;
  logic [23:0] noload_reg;
  logic [15:0] tick_cnt;
  logic        tick;
  logic        chan;
  logic        supply_fail;
  logic [23:0] e_pulse;
  logic [23:0] s_pulse;
  logic [23:0] q_pulse;
  logic [23:0] x1_pulse;
  logic [23:0] x2_pulse;
  logic [1:0]  out_a_select;
  logic [1:0]  out_b_select;
  logic [1:0]  out_c_select;
  logic        paired;
  logic        wr;
  logic        rd_req;
  logic [22:0] mag_a;
  logic [22:0] mag_b;
  logic [22:0] mag_c;
  logic        en_a;
  logic        en_b;
  logic        en_c;
  logic        pls_a;
  logic        pls_b;
  logic        pls_c;
  logic        next_a;
  logic        next_b;
  logic        next_c;
  logic        sign_ab;

  assign out_a_select = mode_reg[MODE_A_LSB +: 2];
  assign out_b_select = mode_reg[MODE_B_LSB +: 2];
  assign out_c_select = mode_reg[MODE_C_LSB +: 2];
  assign paired       = (out_b_select == B_A_ENABLE); // RULE2
  assign rd_req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr           = rd_req && wb_we_i;

  // Supply comparator comes from the analog side
  level_sync fail_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (supply_fail_input_i),
    .sync_o  (supply_fail)
  );

  // Sample strobe from a free-running divider
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_cnt == 16'(SAMPLE_CYC - 1)) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  assign tick          = (tick_cnt == 16'(SAMPLE_CYC - 1));
  assign sample_tick_o = tick;

  // Wishbone acknowledge: one cycle, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= rd_req;
    end
  end

  // Mode register steers all three outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RST;
    end else if (wr && wb_adr_i == OFS_MODE && wb_sel_i[0]) begin
      mode_reg <= wb_dat_i[7:0];
    end
  end

  // Length, rate and threshold settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_len_reg       <= PLEN_RST; // RULE8
      full_scale_rate_reg <= RATE_RST;
      noload_reg          <= NOLOAD_RST;
    end else if (wr) begin
      unique case (wb_adr_i)
        OFS_PLEN:   pulse_len_reg       <= 16'(merge({16'h0000, pulse_len_reg}, wb_dat_i,
                                                     wb_sel_i));
        OFS_RATE:   full_scale_rate_reg <= 24'(merge({8'h00, full_scale_rate_reg}, wb_dat_i,
                                                     wb_sel_i));
        OFS_NOLOAD: noload_reg          <= 24'(merge({8'h00, noload_reg}, wb_dat_i,
                                                     wb_sel_i));
        default:    ;
      endcase
    end
  end

  // Read data, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_req) begin
      unique case (wb_adr_i)
        OFS_MODE:   wb_dat_o <= {24'h000000, mode_reg};
        OFS_PLEN:   wb_dat_o <= {16'h0000, pulse_len_reg};
        OFS_RATE:   wb_dat_o <= {8'h00, full_scale_rate_reg};
        OFS_NOLOAD: wb_dat_o <= {8'h00, noload_reg};
        OFS_STATUS: wb_dat_o <= {24'h000000, chan, supply_fail, voltage_neg_i,
                                 e_pulse[23], q_pulse[23], ~pulse_out_a_n_o,
                                 ~pulse_out_b_n_o, ~pulse_out_c_n_o};
        OFS_EPULSE: wb_dat_o <= {8'h00, e_pulse};
        OFS_QPULSE: wb_dat_o <= {8'h00, q_pulse};
        default:    wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Channel pick: automatic unless software holds it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan <= 1'b0;
    end else begin
      chan <= mode_reg[MODE_HOLD_BIT] ? mode_reg[MODE_CHAN_BIT] : auto_chan_i; // RULE12
    end
  end

  // Pulse registers load once per sample from the chosen channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e_pulse <= 24'h000000;
      s_pulse <= 24'h000000;
      q_pulse <= 24'h000000;
    end else if (tick) begin
      e_pulse <= noload(chan ? act2_i : act1_i, noload_reg); // RULE6 RULE12
      s_pulse <= chan ? app2_i : app1_i;
      q_pulse <= noload(chan ? rea2_i : rea1_i, noload_reg); // RULE6
    end
  end

  // Paired mode: one kind for both channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x1_pulse <= 24'h000000;
      x2_pulse <= 24'h000000;
    end else if (tick) begin
      unique case (out_a_select) // RULE4
        K_ACTIVE: begin
          x1_pulse <= noload(act1_i, noload_reg); // RULE6
          x2_pulse <= noload(act2_i, noload_reg);
        end
        K_APPARENT: begin
          x1_pulse <= app1_i;
          x2_pulse <= app2_i;
        end
        K_REACTIVE: begin
          x1_pulse <= noload(rea1_i, noload_reg); // RULE6
          x2_pulse <= noload(rea2_i, noload_reg);
        end
        K_WIDEBAND: begin
          x1_pulse <= wbr1_i;
          x2_pulse <= wbr2_i;
        end
      endcase
    end
  end

  assign sign_ab = paired ? (x1_pulse[23] | x2_pulse[23]) : (e_pulse[23] | q_pulse[23]);

  // Route magnitudes to the generators; steady outputs keep theirs idle
  always_comb begin
    mag_a = paired ? mag(x1_pulse) : mag(e_pulse); // RULE1 RULE4
    en_a  = 1'b1;
    mag_b = paired ? mag(x2_pulse) : mag(s_pulse);
    en_b  = paired || (out_b_select == B_APPARENT); // RULE2 RULE7
    mag_c = 23'h000000;
    en_c  = 1'b0;
    if (!paired) begin
      unique case (out_c_select) // RULE3
        C_REACTIVE: begin
          mag_c = mag(q_pulse);
          en_c  = 1'b1;
        end
        C_APPARENT: begin
          mag_c = mag(s_pulse);
          en_c  = 1'b1;
        end
        default: begin
          mag_c = 23'h000000;
          en_c  = 1'b0; // RULE7
        end
      endcase
    end
  end

  rate_pulser gen_a (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .enable_i (en_a),
    .mag_i    (mag_a),
    .rate_i   (full_scale_rate_reg),
    .len_i    (pulse_len_reg),
    .pulse_o  (pls_a)
  );

  rate_pulser gen_b (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .enable_i (en_b),
    .mag_i    (mag_b),
    .rate_i   (full_scale_rate_reg),
    .len_i    (pulse_len_reg),
    .pulse_o  (pls_b)
  );

  rate_pulser gen_c (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .enable_i (en_c),
    .mag_i    (mag_c),
    .rate_i   (full_scale_rate_reg),
    .len_i    (pulse_len_reg),
    .pulse_o  (pls_c)
  );

  // Output selection, asserted means driven low
  always_comb begin
    next_a = pls_a;
    next_b = pls_b;
    next_c = 1'b0;
    if (!paired) begin
      unique case (out_b_select)
        B_SIGN:     next_b = sign_ab; // RULE1
        B_CHANNEL:  next_b = chan; // RULE11
        default:    next_b = pls_b;
      endcase
      unique case (out_c_select)
        C_FAIL:     next_c = supply_fail; // RULE13
        C_VSIGN:    next_c = voltage_neg_i;
        default:    next_c = pls_c;
      endcase
    end else begin
      unique case (out_c_select) // RULE5
        CP_FAIL:    next_c = supply_fail;
        CP_SIGN:    next_c = sign_ab;
        default:    next_c = 1'b0;
      endcase
    end
  end

  // Registered pins, idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_out_a_n_o <= 1'b1;
      pulse_out_b_n_o <= 1'b1;
      pulse_out_c_n_o <= 1'b1;
    end else begin
      pulse_out_a_n_o <= ~next_a;
      pulse_out_b_n_o <= ~next_b;
      pulse_out_c_n_o <= ~next_c;
    end
  end

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_len_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> pulse_len_reg == 16'h0001) else $error("length reset wrong"); // RULE8
  a_noload_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && ({1'b0, mag(chan ? act2_i : act1_i)} < noload_reg)
    |=> e_pulse == 24'h000000) else $error("small active not zeroed"); // RULE6
  a_chan_held: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg[MODE_HOLD_BIT] [*2] |-> chan == $past(mode_reg[MODE_CHAN_BIT]))
    else $error("held channel not followed"); // RULE12
  a_chan_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    !paired && out_b_select == B_CHANNEL |=> pulse_out_b_n_o == !$past(chan))
    else $error("channel output wrong"); // RULE11
  a_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg == MODE_RST |=> pulse_out_a_n_o == !$past(pls_a))
    else $error("output a not active pulses"); // RULE1
  a_fail_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    paired && out_c_select == CP_FAIL |=> pulse_out_c_n_o == !$past(supply_fail))
    else $error("paired fail status wrong"); // RULE5
  a_vsign_c: assert property (@(posedge clk_i) disable iff (rst_i)
    !paired && out_c_select == C_VSIGN |=> pulse_out_c_n_o == !$past(voltage_neg_i))
    else $error("voltage sign wrong"); // RULE3
  a_steady_b: assert property (@(posedge clk_i) disable iff (rst_i)
    !paired && out_b_select == B_SIGN |=> pulse_out_b_n_o == !$past(sign_ab) && !pls_b)
    else $error("sign output not a steady level"); // RULE1 RULE7
endmodule

//--- pulse_meter.sv
// Meter-side pulse counter for one active-low energy output.
// Assumes the line idles high, pulses low and is sampled on the system clock.
module pulse_meter (
  input  wire logic        clk_i,     // System clock
  input  wire logic        line_n_i,  // Watched output, active low
  output logic      [15:0] count_o,   // Falling edges seen
  output logic      [15:0] width_o    // Clocks low in last pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        last_n = 1'b1;   // Previous level
  logic [15:0] run    = 16'h0;  // Clocks low so far
  logic [15:0] cnt    = 16'h0;  // Pulse tally
  logic [15:0] wid    = 16'h0;  // Last low time

  // Unknown levels never count, so a stuck X shows up as missing pulses
  always_ff @(posedge clk_i) begin
    last_n <= line_n_i;
    run    <= (line_n_i === 1'b0) ? run + 16'h0001 : 16'h0000;
    if (line_n_i === 1'b0 && last_n === 1'b1) begin
      cnt <= cnt + 16'h0001;
    end
    if (line_n_i === 1'b1 && last_n === 1'b0) begin
      wid <= run;
    end
  end

  assign count_o = cnt;
  assign width_o = wid;
endmodule

//--- test_energy_pulse_output_unit.sv
// Self-checking bench for the energy pulse output unit.
// Assumes the Wishbone slave acks one cycle after the request edge.
module test_energy_pulse_output_unit import epu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC    = 20;     // Short sample period for simulation
  localparam int LIMIT = 60000;  // Clock ceiling for the whole run
  logic        clk_i, rst_i, cyc, stb, we, auto_c, vneg, sfail, tick;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q;
  logic        ack;
  logic [23:0] e [8];
  logic [23:0] rate_val;
  logic        out_n [3];
  logic [15:0] cnt [3];
  logic [15:0] wid [3];
  logic [15:0] c0 [3];
  int          n_errors, cmp_count, cycles;

  energy_pulse_output_unit #(.SAMPLE_CYC(SC)) u_energy_pulse_output_unit (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .act1_i(e[0]), .act2_i(e[1]), .app1_i(e[2]), .app2_i(e[3]), .rea1_i(e[4]),
    .rea2_i(e[5]), .wbr1_i(e[6]), .wbr2_i(e[7]), .auto_chan_i(auto_c),
    .voltage_neg_i(vneg), .supply_fail_input_i(sfail), .pulse_out_a_n_o(out_n[0]),
    .pulse_out_b_n_o(out_n[1]), .pulse_out_c_n_o(out_n[2]), .sample_tick_o(tick));
  pulse_meter u_meter_a (.clk_i(clk_i), .line_n_i(out_n[0]), .count_o(cnt[0]), .width_o(wid[0]));
  pulse_meter u_meter_b (.clk_i(clk_i), .line_n_i(out_n[1]), .count_o(cnt[1]), .width_o(wid[1]));
  pulse_meter u_meter_c (.clk_i(clk_i), .line_n_i(out_n[2]), .count_o(cnt[2]), .width_o(wid[2]));

  // Clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      chk("wb_ack_o", 32'h1, 32'h0);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // Sample strobe must come once every SC clocks
  task automatic chk_tick();
    int t;
    t = 0;
    @(posedge clk_i iff tick === 1'b1);
    @(posedge clk_i);
    while (tick !== 1'b1 && t < 4 * SC) begin
      @(posedge clk_i);
      t++;
    end
    chk("sample tick period", 32'(SC), 32'(t + 1));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk("register", exp, q);
  endtask

  task automatic mode(input logic [1:0] a, b, c, input logic hold, chan);
    wb(1'b1, OFS_MODE, {24'h0, chan, hold, c, b, a});
  endtask

  // Settle two samples, then snapshot the meters and let nt samples pass
  task automatic run(input int nt);
    repeat (2 * SC) @(posedge clk_i);
    c0 = cnt;
    repeat (nt * SC) @(posedge clk_i);
  endtask

  // One pulse either side allowed for accumulator phase; none when none due
  task automatic chk_rate(input int i, input int nt, input logic [23:0] mag);
    longint x;
    int     d;
    x = (longint'(nt) * longint'(rate_val) * longint'(mag)) >> 48;
    d = int'(cnt[i] - c0[i]);
    cmp_count++;
    if ((x == 0) ? (d != 0) : (d > x + 1 || d + 1 < x)) begin
      n_errors++;
      $display("wrong value pulse count %0d expected %0d seen %0d", i, x, d);
    end
  endtask

  // Steady level must hold and produce no edges while the rate is high
  task automatic lvl(input int i, input logic exp);
    run(6);
    chk("steady level", {31'h0, exp}, {31'h0, out_n[i]});
    chk("steady edges", 32'h0, {16'h0, cnt[i] - c0[i]});
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, auto_c, vneg, sfail} = 6'h00;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    rate_val = 24'h800000;
    foreach (e[j]) e[j] = 24'h000000;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped offset
    rdc(OFS_MODE, 32'h0);
    rdc(OFS_PLEN, 32'h1);
    rdc(OFS_RATE, 32'h0);
    rdc(OFS_NOLOAD, 32'h0);
    rdc(8'h1C, 32'h0);
    chk_tick();
    // Default modes with negative active energy
    wb(1'b1, OFS_PLEN, 32'h3);
    wb(1'b1, OFS_RATE, {8'h0, rate_val});
    e[0] <= 24'hC00000;
    e[4] <= 24'h200000;
    run(80);
    chk_rate(0, 80, 24'h400000);
    chk_rate(2, 80, 24'h200000);
    chk("sign b", 32'h0, {31'h0, out_n[1]});
    chk("width a", 32'(3 * SC), {16'h0, wid[0]});
    e[0] <= 24'h400000;
    lvl(1, 1'b1);
    // Threshold above both magnitudes
    wb(1'b1, OFS_NOLOAD, 32'h500000);
    run(40);
    chk_rate(0, 40, 24'h0);
    chk_rate(2, 40, 24'h0);
    rdc(OFS_EPULSE, 32'h0);
    rdc(OFS_QPULSE, 32'h0);
    wb(1'b1, OFS_NOLOAD, 32'h0);
    // Apparent energy on b and c
    e[2] <= 24'h400000;
    mode(2'h0, B_APPARENT, C_APPARENT, 1'b0, 1'b0);
    run(80);
    chk_rate(1, 80, 24'h400000);
    chk_rate(2, 80, 24'h400000);
    // Channel in use, held by software, with fail and voltage sign on c
    sfail <= 1'b1;
    mode(2'h0, B_CHANNEL, C_FAIL, 1'b1, 1'b1);
    lvl(1, 1'b0);
    lvl(2, 1'b0);
    vneg <= 1'b1;
    mode(2'h0, B_CHANNEL, C_VSIGN, 1'b1, 1'b0);
    lvl(1, 1'b1);
    lvl(2, 1'b0);
    // Automatic pick of channel 2
    auto_c <= 1'b1;
    vneg   <= 1'b0;
    mode(2'h0, B_CHANNEL, C_VSIGN, 1'b0, 1'b0);
    lvl(1, 1'b0);
    lvl(2, 1'b1);
    // Paired mode: a shows channel 1, b channel 2 of each kind
    auto_c <= 1'b0;
    sfail  <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      // One assignment per input, channel 1 at half scale and channel 2 at a quarter of this kind
      foreach (e[j]) begin
        e[j] <= (j == 2 * k) ? 24'h400000 : (j == 2 * k + 1) ? 24'h200000 : 24'h000000;
      end
      mode(2'(k), B_A_ENABLE, CP_FAIL, 1'b1, 1'b0);
      run(80);
      chk_rate(0, 80, 24'h400000);
      chk_rate(1, 80, 24'h200000);
    end
    lvl(2, 1'b1);
    e[7] <= 24'hE00000;
    mode(K_WIDEBAND, B_A_ENABLE, CP_SIGN, 1'b1, 1'b0);
    lvl(2, 1'b0);
    complete_run();
  end
endmodule
